// ==== hw/fcd_defines.vh ====
// Constants for the FPU convert and divide slice
`ifndef FCD_DEFINES_VH
`define FCD_DEFINES_VH
// Register byte offsets
`define FCD_A_CTRL 8'h00
`define FCD_A_STAT 8'h04
`define FCD_A_COMM 8'h08
`define FCD_A_ISSUE 8'h0C
`define FCD_A_PC 8'h10
`define FCD_A_FRBLK 2'b01
// Control register fields
`define FCD_B_PR 0
`define FCD_B_DN 1
`define FCD_F_RM 3:2
`define FCD_F_EN 8:4
`define FCD_CTRL_RST 9'h000
// Cause bit positions, enables share I..V
`define FCD_C_I 0
`define FCD_C_U 1
`define FCD_C_O 2
`define FCD_C_Z 3
`define FCD_C_V 4
`define FCD_C_E 5
// Status register fields
`define FCD_F_FLG 12:8
`define FCD_B_BSY 16
`define FCD_B_TRP 17
`define FCD_B_UND 18
// Opcode matching
`define FCD_OP_HI 4'hF
`define FCD_OP_DIV 4'h3
`define FCD_OP_CNVDS 8'hBD
`define FCD_OP_CNVSD 8'hAD
`define FCD_PC_STEP 32'h00000002
// Cycle counts per instruction
`define FCD_CYC_CNV 5'h01
`define FCD_CYC_DIVS 5'h0E
`define FCD_CYC_DIVD 5'h1E
// Single precision special words
`define FCD_S_PINF 32'h7F800000
`define FCD_S_NINF 32'hFF800000
`define FCD_S_QNAN 32'h7FBFFFFF
`define FCD_S_MIN 31'h00800000
`define FCD_S_INFM 31'h7F800000
`define FCD_S_QLIM 31'h7FC00000
// Double precision special fields
`define FCD_D_QNAN 64'h7FF7FFFFFFFFFFFF
`define FCD_D_EXPMX 11'h7FF
// Narrowing of the low word
`define FCD_LO_INX 32'h1FFFFFFF
`define FCD_LO_TRZ 32'hE0000000
`define FCD_LO_STK 32'h0FFFFFFF
`define FCD_LO_G 28
`define FCD_S_LSB 29
`define FCD_S_FRAC 51:29
`define FCD_S_ULP 54'h00000020000000
`define FCD_RM_RTZ 2'h1
// Exponent figures
`define FCD_D_OVT 11'h47E
`define FCD_D_UNT 11'h380
`define FCD_EXP_ADJ 13'sh0380
`define FCD_BIAS_S 13'sh007F
`define FCD_BIAS_D 13'sh03FF
`define FCD_EMAX_S 13'sh00FF
`define FCD_EMAX_D 13'sh07FF
`define FCD_DIV_UNT 13'sh0001
`endif

// ==== hw/fcd_unit.v ====
// FPU convert and divide slice with APB register access
`timescale 1ns/1ps
`include "fcd_defines.vh"
// Summary of operation
// - Double to single into comm register, one cycle
// - Mode zero: conversion opcodes are undefined
// - Inexact enable always traps; O/U on conditions
// - Trapped conversion leaves comm register unchanged
// - Fixed results for infinities, quiet NaN; denormal errors
// - Signalling NaN narrow: invalid, quiet result or trap
// - Discarded low 29 bits nonzero set inexact
// - Round-to-zero mode masks low word bits
// - Narrow trap conditions on exponent limits
// - Single to double into pair, one cycle
// - Widen: copy zero/inf, denormal errors, NaN handling
// - Single classify: zero, denormal, normal by magnitude
// - Single classify: infinity, quiet, signalling NaN
// - Denormal-as-zero bit turns denormals into zero
// - Single divide writes destination after 14 cycles
// - Double divide writes destination pair after 30 cycles
// - Divide: signalling invalid, else quiet NaN passes
// - Normal divisor: inf/zero dividend, denormal, normal
// - Trapped divide leaves destination unchanged
module fcd_unit (
  input wire mclk, // Core clock
  input wire rst, // Asynchronous reset, active high
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB transfer done
  output reg pslverr, // APB error on unmapped address
  output reg fpu_trap, // Exception trap pulse
  output reg undef_op, // Undefined operation pulse
  output reg instr_done // Instruction retired pulse
);

  ////////////////////////////////////////////////////////////////////
  // Local codes
  localparam [2:0] C_NORM = 3'h0; // Operand classes
  localparam [2:0] C_ZERO = 3'h1;
  localparam [2:0] C_DEN = 3'h2;
  localparam [2:0] C_INF = 3'h3;
  localparam [2:0] C_QNAN = 3'h4;
  localparam [2:0] C_SIGNALLING_NAN = 3'h5;
  localparam [1:0] D_NONE = 2'h0; // Destination kinds
  localparam [1:0] D_COMM = 2'h1;
  localparam [1:0] D_SGL = 2'h2;
  localparam [1:0] D_PAIR = 2'h3;
  localparam QT_S = 25; // Quotient top bit, single
  localparam QT_D = 57; // Quotient top bit, double

  ////////////////////////////////////////////////////////////////////
  // Functions
  // Single word class from magnitude
  function [2:0] cls_s;
    input [31:0] w;
    input dn;
    begin
      if (w[30:0] < `FCD_S_MIN)
        cls_s = (dn || w[30:0] == 31'h0) ? C_ZERO : C_DEN;
      else if (w[30:0] < `FCD_S_INFM)
        cls_s = C_NORM;
      else if (w[30:0] == `FCD_S_INFM)
        cls_s = C_INF;
      else if (w[30:0] < `FCD_S_QLIM)
        cls_s = C_QNAN;
      else
        cls_s = C_SIGNALLING_NAN;
    end
  endfunction

  // Double word class, same ordering of NaNs
  function [2:0] cls_d;
    input [63:0] w;
    input dn;
    begin
      if (w[62:52] == 11'h000)
        cls_d = (dn || w[51:0] == 52'h0) ? C_ZERO : C_DEN;
      else if (w[62:52] != `FCD_D_EXPMX)
        cls_d = C_NORM;
      else if (w[51:0] == 52'h0)
        cls_d = C_INF;
      else if (!w[51])
        cls_d = C_QNAN;
      else
        cls_d = C_SIGNALLING_NAN;
    end
  endfunction

  // Unpack to {exponent, mantissa with hidden one}
  function [65:0] unp;
    input [63:0] w;
    input dbl;
    begin
      if (dbl)
        unp = {2'h0, w[62:52], 1'b1, w[51:0]};
      else
        unp = {5'h00, w[62:55], 1'b1, w[54:32], 29'h0};
    end
  endfunction

  // One restoring divide step: {quotient bit, next remainder}
  function [54:0] dstep;
    input [53:0] r;
    input [52:0] d;
    reg [53:0] t;
    begin
      t = r - {1'b0, d};
      if (r >= {1'b0, d})
        dstep = {1'b1, t[52:0], 1'b0};
      else
        dstep = {1'b0, r[52:0], 1'b0};
    end
  endfunction

  // Round, range check and pack; returns {O, U, I, result}
  function [66:0] fin;
    input sg;
    input dbl;
    input signed [12:0] e;
    input [52:0] m;
    input g;
    input s;
    input [1:0] rm;
    reg [53:0] sm;
    reg signed [12:0] ef;
    reg up;
    begin
      up = (rm != `FCD_RM_RTZ) && g && (s || (dbl ? m[0] : m[`FCD_S_LSB]));
      sm = {1'b0, m} + (up ? (dbl ? 54'h1 : `FCD_S_ULP) : 54'h0);
      ef = sm[53] ? e + 13'sh0001 : e;
      if (sm[53])
        sm = sm >> 1;
      if (m == 53'h0)
        fin = {3'h0, sg, 63'h0}; // Signed zero, exact
      else if (ef >= (dbl ? `FCD_EMAX_D : `FCD_EMAX_S))
        fin = dbl ? {3'h5, sg, `FCD_D_EXPMX, 52'h0} : {3'h5, sg, `FCD_S_INFM, 32'h0};
      else if (ef <= 13'sh0000)
        fin = {3'h3, sg, 63'h0}; // Flushed, no denormal output
      else if (dbl)
        fin = {2'h0, g | s, sg, ef[10:0], sm[51:0]};
      else
        fin = {2'h0, g | s, sg, ef[7:0], sm[`FCD_S_FRAC], 32'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State
  reg [31:0] fr_r [0:15]; // Single registers, pairs are even/odd
  reg [8:0] ctrl_r; // Mode, denormal, rounding, trap enables
  reg [5:0] cause_r; // Exception cause field
  reg [4:0] flags_r; // Sticky exception flags
  reg [31:0] comm_r; // Communication register
  reg [31:0] pc_r; // Program counter
  reg [15:0] lop_r; // Last issued opcode
  reg und_r; // Last issue was undefined
  reg trp_r; // Last instruction trapped
  reg busy_r; // Instruction in flight
  reg [4:0] cnt_r; // Cycles left
  reg kdiv_r; // Normal divide running
  reg dbl_r; // Double precision in flight
  reg [1:0] dsel_r; // Destination kind
  reg [3:0] dst_r; // Destination index
  reg [63:0] res_r; // Pending result, single in upper word
  reg [5:0] pcs_r; // Pending cause
  reg os_r; // Overflow trap condition
  reg us_r; // Underflow trap condition
  reg sgn_r; // Quotient sign
  reg signed [12:0] ex_r; // Quotient exponent before normalising
  reg [53:0] rem_r; // Divide remainder
  reg [52:0] dvs_r; // Divisor mantissa
  reg [57:0] q_r; // Quotient bits
  integer i;

  wire pr = ctrl_r[`FCD_B_PR];
  wire dn = ctrl_r[`FCD_B_DN];
  wire [1:0] rm = ctrl_r[`FCD_F_RM];
  wire [4:0] en = ctrl_r[`FCD_F_EN];

  ////////////////////////////////////////////////////////////////////
  // APB decode
  wire acc = psel && penable;
  wire go_a = acc && !pready && !busy_r; // Stall while busy
  wire go_b = acc && pready; // Completing edge
  wire frh = (paddr[7:6] == `FCD_A_FRBLK);
  wire [3:0] fri = paddr[5:2];
  reg hit;
  reg [31:0] rdv;

  // Read mux and map check
  always @* begin
    hit = (paddr[1:0] == 2'h0);
    rdv = 32'h0;
    if (frh)
      rdv = fr_r[fri];
    else
      case (paddr)
        `FCD_A_CTRL: rdv = {23'h0, ctrl_r};
        `FCD_A_STAT: rdv = {13'h0, und_r, trp_r, busy_r, 3'h0, flags_r, 2'h0, cause_r};
        `FCD_A_COMM: rdv = comm_r;
        `FCD_A_ISSUE: rdv = {16'h0, lop_r};
        `FCD_A_PC: rdv = pc_r;
        default: hit = 1'b0; // Unmapped
      endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Issue decode, taken from write data of the issue register
  wire [15:0] op = pwdata[15:0];
  wire [3:0] p1 = {op[11:9], 1'b0}; // First pair base
  wire [3:0] p2 = {op[7:5], 1'b0}; // Second pair base
  wire [3:0] p1o = {op[11:9], 1'b1};
  wire [3:0] p2o = {op[7:5], 1'b1};
  wire is_dv = (op[15:12] == `FCD_OP_HI) && (op[3:0] == `FCD_OP_DIV);
  wire is_ds = (op[15:12] == `FCD_OP_HI) && !op[8] && (op[7:0] == `FCD_OP_CNVDS);
  wire is_sd = (op[15:12] == `FCD_OP_HI) && !op[8] && (op[7:0] == `FCD_OP_CNVSD);
  reg [63:0] wa, wb, ws, qn, infx;
  reg [65:0] ua, ub;
  reg [2:0] ca, cb, cs, cf;
  reg signed [12:0] ea, eb, ed;
  reg [31:0] lom;
  reg [12:0] wx; // Widened exponent, rebiased to double
  reg [66:0] cv;
  reg sx;
  reg i_und, i_div, i_os, i_us;
  reg [1:0] i_dsel;
  reg [3:0] i_dst;
  reg [63:0] i_res;
  reg [5:0] i_cs;
  reg [4:0] i_cyc;

  // Classify and settle every non-iterative outcome at issue
  always @* begin
    wa = pr ? {fr_r[p1], fr_r[p1o]} : {fr_r[op[11:8]], 32'h0};
    wb = pr ? {fr_r[p2], fr_r[p2o]} : {fr_r[op[7:4]], 32'h0};
    ws = {fr_r[p1], fr_r[p1o]};
    ua = unp(wa, pr);
    ub = unp(wb, pr);
    ea = ua[65:53];
    eb = ub[65:53];
    ca = pr ? cls_d(wa, dn) : cls_s(wa[63:32], dn);
    cb = pr ? cls_d(wb, dn) : cls_s(wb[63:32], dn);
    cs = cls_d(ws, dn);
    cf = cls_s(comm_r, dn);
    sx = wa[63] ^ wb[63];
    qn = pr ? `FCD_D_QNAN : {`FCD_S_QNAN, 32'h0};
    infx = pr ? {sx, `FCD_D_EXPMX, 52'h0} : {sx, `FCD_S_INFM, 32'h0};
    ed = {2'h0, ws[62:52]};
    // Rebias in its own field so the carry cannot land in the fraction
    wx = {5'h00, comm_r[30:23]} + `FCD_EXP_ADJ;
    lom = (rm == `FCD_RM_RTZ) ? (ws[31:0] & `FCD_LO_TRZ) : ws[31:0];
    cv = fin(ws[63], 1'b0, ed - `FCD_EXP_ADJ,
      (cs == C_ZERO) ? 53'h0 : {1'b1, ws[51:32], lom},
      lom[`FCD_LO_G], (lom & `FCD_LO_STK) != 32'h0, rm);
    i_und = 1'b0;
    i_div = 1'b0;
    i_os = 1'b0;
    i_us = 1'b0;
    i_dsel = D_NONE;
    i_dst = pr ? p1 : op[11:8];
    i_res = 64'h0;
    i_cs = 6'h00;
    i_cyc = `FCD_CYC_CNV;
    if (is_ds && pr) begin
      i_dsel = D_COMM;
      case (cs)
        C_DEN: i_cs[`FCD_C_E] = 1'b1;
        C_INF: i_res = {ws[63] ? `FCD_S_NINF : `FCD_S_PINF, 32'h0};
        C_QNAN: i_res = {`FCD_S_QNAN, 32'h0};
        C_SIGNALLING_NAN: begin
          i_cs[`FCD_C_V] = 1'b1;
          i_res = {`FCD_S_QNAN, 32'h0};
        end
        default: begin
          i_res = cv[63:0];
          i_cs = {3'h0, cv[66:65], cv[64] | ((ws[31:0] & `FCD_LO_INX) != 32'h0)};
          i_os = (cs == C_NORM) && (ws[62:52] >= `FCD_D_OVT);
          i_us = (cs == C_NORM) && (ws[62:52] <= `FCD_D_UNT);
        end
      endcase
    end else if (is_sd && pr) begin
      i_dsel = D_PAIR;
      case (cf)
        C_ZERO: i_res = {comm_r[31], 63'h0};
        C_INF: i_res = {comm_r[31], `FCD_D_EXPMX, 52'h0};
        C_DEN: i_cs[`FCD_C_E] = 1'b1;
        C_QNAN: i_res = `FCD_D_QNAN;
        C_SIGNALLING_NAN: begin
          i_cs[`FCD_C_V] = 1'b1;
          i_res = `FCD_D_QNAN;
        end
        default: i_res = {comm_r[31], wx[10:0], comm_r[22:0], 29'h0};
      endcase
    end else if (is_dv && (!pr || (!op[8] && !op[4]))) begin
      i_dsel = pr ? D_PAIR : D_SGL;
      i_cyc = pr ? `FCD_CYC_DIVD : `FCD_CYC_DIVS;
      i_os = (ea - eb + (pr ? `FCD_BIAS_D : `FCD_BIAS_S)) >= (pr ? `FCD_EMAX_D : `FCD_EMAX_S);
      i_us = (ea - eb + (pr ? `FCD_BIAS_D : `FCD_BIAS_S)) <= `FCD_DIV_UNT;
      if (ca == C_SIGNALLING_NAN || cb == C_SIGNALLING_NAN) begin
        i_cs[`FCD_C_V] = 1'b1;
        i_res = qn;
      end else if (ca == C_QNAN || cb == C_QNAN)
        i_res = qn;
      else
        case (cb)
          C_NORM: begin
            if (ca == C_INF)
              i_res = infx;
            else if (ca == C_ZERO)
              i_res = {sx, 63'h0};
            else if (ca == C_DEN)
              i_cs[`FCD_C_E] = 1'b1;
            else
              i_div = 1'b1;
          end
          C_ZERO: begin
            if (ca == C_ZERO) begin
              i_cs[`FCD_C_V] = 1'b1;
              i_res = qn;
            end else begin
              i_cs[`FCD_C_Z] = (ca != C_INF); // Divide by zero
              i_res = infx;
            end
          end
          C_INF: begin
            if (ca == C_DEN)
              i_cs[`FCD_C_E] = 1'b1;
            else if (ca == C_INF) begin
              i_cs[`FCD_C_V] = 1'b1;
              i_res = qn;
            end else
              i_res = {sx, 63'h0};
          end
          default: i_cs[`FCD_C_E] = 1'b1; // Denormal divisor
        endcase
    end else
      i_und = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // Divide finish and trap decision
  reg top, g, s, trap;
  reg [52:0] dm;
  reg [66:0] fd;
  reg [5:0] fc;
  reg [63:0] fres;
  reg [54:0] st1, st2;

  // Normalise the quotient and pick the final cause
  always @* begin
    st1 = dstep(rem_r, dvs_r);
    st2 = dstep(st1[53:0], dvs_r);
    top = dbl_r ? q_r[QT_D] : q_r[QT_S];
    if (dbl_r) begin
      dm = top ? q_r[QT_D:QT_D-52] : q_r[QT_D-1:QT_D-53];
      g = top ? q_r[QT_D-53] : q_r[QT_D-54];
      s = (top ? |q_r[QT_D-54:0] : |q_r[QT_D-55:0]) | (rem_r != 54'h0);
    end else begin
      dm = top ? {q_r[QT_S:QT_S-23], 29'h0} : {q_r[QT_S-1:QT_S-24], 29'h0};
      g = top ? q_r[QT_S-24] : q_r[QT_S-25];
      s = (top & q_r[QT_S-25]) | (rem_r != 54'h0);
    end
    fd = fin(sgn_r, dbl_r, top ? ex_r : ex_r - 13'sh0001, dm, g, s, rm);
    fc = kdiv_r ? {3'h0, fd[66:64]} : pcs_r;
    fres = kdiv_r ? fd[63:0] : res_r;
    trap = en[`FCD_C_I] | fc[`FCD_C_E]
      | (fc[`FCD_C_V] & en[`FCD_C_V]) | (fc[`FCD_C_Z] & en[`FCD_C_Z])
      | (en[`FCD_C_O] & (fc[`FCD_C_O] | os_r))
      | (en[`FCD_C_U] & (fc[`FCD_C_U] | us_r));
  end

  ////////////////////////////////////////////////////////////////////
  // Registers, bus handshake and instruction sequencing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 16; i = i + 1)
        fr_r[i] <= 32'h0;
      ctrl_r <= `FCD_CTRL_RST;
      cause_r <= 6'h00;
      flags_r <= 5'h00;
      comm_r <= 32'h0;
      pc_r <= 32'h0;
      lop_r <= 16'h0;
      und_r <= 1'b0;
      trp_r <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
      kdiv_r <= 1'b0;
      dbl_r <= 1'b0;
      dsel_r <= D_NONE;
      dst_r <= 4'h0;
      res_r <= 64'h0;
      pcs_r <= 6'h00;
      os_r <= 1'b0;
      us_r <= 1'b0;
      sgn_r <= 1'b0;
      ex_r <= 13'sh0000;
      rem_r <= 54'h0;
      dvs_r <= 53'h0;
      q_r <= 58'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fpu_trap <= 1'b0;
      undef_op <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      fpu_trap <= 1'b0;
      undef_op <= 1'b0;
      instr_done <= 1'b0;
      // Answer one cycle into the access phase
      if (go_a) begin
        pready <= 1'b1;
        prdata <= (hit && !pwrite) ? rdv : 32'h0;
        pslverr <= !hit;
      end else if (go_b || !acc) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      // Writes land on the completing edge
      if (go_b && pwrite && hit) begin
        if (frh)
          fr_r[fri] <= pwdata;
        else
          case (paddr)
            `FCD_A_CTRL: ctrl_r <= pwdata[8:0];
            `FCD_A_STAT: flags_r <= flags_r & ~pwdata[`FCD_F_FLG]; // Write one to clear
            `FCD_A_COMM: comm_r <= pwdata;
            `FCD_A_PC: pc_r <= pwdata;
            `FCD_A_ISSUE: begin
              lop_r <= op;
              und_r <= i_und;
              if (i_und)
                undef_op <= 1'b1;
              else begin
                pc_r <= pc_r + `FCD_PC_STEP;
                cause_r <= 6'h00;
                busy_r <= 1'b1;
                cnt_r <= i_cyc - 5'h01;
                kdiv_r <= i_div;
                dbl_r <= pr;
                dsel_r <= i_dsel;
                dst_r <= i_dst;
                res_r <= i_res;
                pcs_r <= i_cs;
                os_r <= i_os;
                us_r <= i_us;
                sgn_r <= sx;
                ex_r <= ea - eb + (pr ? `FCD_BIAS_D : `FCD_BIAS_S);
                rem_r <= {1'b0, ua[52:0]};
                dvs_r <= ub[52:0];
                q_r <= 58'h0;
              end
            end
            default: ;
          endcase
      end
      // Two quotient bits per cycle until the last cycle
      if (busy_r && cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
        if (kdiv_r) begin
          q_r <= {q_r[55:0], st1[54], st2[54]};
          rem_r <= st2[53:0];
        end
      end
      // Retire: causes, flags, then write back unless trapped
      if (busy_r && cnt_r == 5'h00) begin
        busy_r <= 1'b0;
        kdiv_r <= 1'b0;
        instr_done <= 1'b1;
        cause_r <= fc;
        flags_r <= flags_r | fc[4:0]; // Set wins over a same-cycle clear
        trp_r <= trap;
        fpu_trap <= trap;
        if (!trap)
          case (dsel_r)
            D_COMM: comm_r <= fres[63:32];
            D_SGL: fr_r[dst_r] <= fres[63:32];
            D_PAIR: begin
              fr_r[dst_r] <= fres[63:32];
              fr_r[dst_r | 4'h1] <= fres[31:0];
            end
            default: ;
          endcase
      end
    end
  end

endmodule // fcd_unit

// ==== testbench/fcd_unit_properties.sv ====
// Timing checks on the convert and divide slice ports
`timescale 1ns/1ps
module fcd_unit_chk (
  input wire mclk, // Core clock
  input wire rst, // Reset
  input wire psel, // Select
  input wire penable, // Access phase
  input wire pwrite, // Direction
  input wire [7:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Done
  input wire pslverr, // Error
  input wire fpu_trap, // Trap pulse
  input wire undef_op, // Undefined pulse
  input wire instr_done // Retire pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Issue edge and opcode class
  wire wdone = psel && penable && pready && pwrite;
  wire iss = wdone && (paddr == 8'h0C);
  wire opf = pwdata[15:12] == 4'hF;
  wire cnv = opf && !pwdata[8] && (pwdata[7:0] == 8'hBD || pwdata[7:0] == 8'hAD);
  wire dvd = opf && (pwdata[3:0] == 4'h3);
  wire ret = instr_done || fpu_trap;
  reg mode_r; // Shadow of precision mode
  reg en_i_r; // Shadow of inexact enable
  ////////////////////////////////////////////////////////////////
  // Shadow control bits, updated where the write lands
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= 1'b0;
      en_i_r <= 1'b0;
    end else if (wdone && paddr == 8'h00) begin
      mode_r <= pwdata[0];
      en_i_r <= pwdata[4];
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_CNV_ONE: assert property (iss && cnv && mode_r |-> ##1 !ret ##1 ret)
    else $error("conversion did not retire after one cycle");
  AST_CNV_DEF: assert property (iss && cnv && mode_r |=> !undef_op)
    else $error("defined conversion flagged undefined");
  AST_CNV_UNDEF: assert property (iss && cnv && !mode_r |-> ##1 undef_op ##1 !ret)
    else $error("conversion in mode zero not refused");
  AST_UNDEF_CAUSE: assert property ($rose(undef_op) |-> $past(iss))
    else $error("undefined pulse without issue");
  AST_TRAP_I: assert property (iss && cnv && mode_r && en_i_r |-> ##2 fpu_trap)
    else $error("inexact enable did not trap");
  AST_DIV_S: assert property (iss && dvd && !mode_r |-> ##14 !ret ##1 ret)
    else $error("single divide not 14 cycles");
  AST_DIV_D: assert property (iss && dvd && mode_r && !pwdata[8] && !pwdata[4]
    |-> ##30 !ret ##1 ret)
    else $error("double divide not 30 cycles");
  AST_DIV_QUIET: assert property (iss && dvd |=> !ret [*8])
    else $error("divide retired early");
  AST_DIV_D_UNDEF: assert property (iss && dvd && mode_r && pwdata[4] |=> undef_op)
    else $error("odd double divide not refused");
endmodule // fcd_unit_chk
bind fcd_unit fcd_unit_chk i_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fpu_trap(fpu_trap), .undef_op(undef_op), .instr_done(instr_done));

// ==== testbench/fcd_host.sv ====
// APB master standing in for the core issue logic
`timescale 1ns/1ps
module fcd_host (
  input wire mclk, // Core clock
  output reg psel = 1'b0, // Select
  output reg penable = 1'b0, // Access phase
  output reg pwrite = 1'b0, // Direction
  output reg [7:0] paddr = 8'h00, // Address
  output reg [31:0] pwdata = 32'h00000000, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Done
  input wire pslverr // Error
);
  ////////////////////////////////////////////////////////////////
  // One transfer, held until pready is sampled high
  task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rd, output e);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // Busy slice stalls until it retires; the bench timeout ends a hang
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so stale values never look valid
      paddr <= ~a;
      pwdata <= ~wd;
    end
  endtask
endmodule // fcd_host

// ==== testbench/tb.sv ====
// Self-checking bench for the convert and divide slice
`timescale 1ns/1ps
module tb;
  reg mclk = 1'b0; // Core clock
  reg rst = 1'b1; // Reset
  wire psel, penable, pwrite, pready, pslverr, fpu_trap, undef_op, instr_done;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer cyc = 0; // Hang guard
  integer tn = 0; // Test number
  reg [31:0] pc_e = 32'h00000000; // Expected pc
  reg [31:0] rdv;
  reg er;
  always #2.5 mclk = ~mclk;
  fcd_unit i_fcd_unit (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fpu_trap(fpu_trap), .undef_op(undef_op), .instr_done(instr_done));
  fcd_host i_fcd_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk32(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    begin
      chk32({31'h0, g}, {31'h0, e});
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      i_fcd_host.xfer(1'b1, a, d, rdv, er);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      i_fcd_host.xfer(1'b0, a, 32'h00000000, d, er);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Load operands, issue, time the retire, check result and status
  task run(input [31:0] ctl, x, l, y, input [15:0] op, input [31:0] ev,
    input [5:0] ec, input et, input [5:0] nk);
    integer k;
    reg tr;
    begin
      wr(8'h00, ctl);
      wr(8'h40, x);
      wr(8'h44, l);
      wr(8'h48, y);
      wr(8'h08, y);
      wr(8'h04, 32'h00001F00);
      wr(8'h0C, {16'h0000, op});
      k = 0;
      tr = 1'b0;
      do begin
        @(posedge mclk);
        k = k + 1;
        tr = fpu_trap;
      end while (!(instr_done || fpu_trap || undef_op) && k < 40);
      chk32(k, {26'h0, nk});
      chk1(tr, et);
      if (nk != 6'h01) pc_e = pc_e + 32'h00000002;
      rd((op[7:0] == 8'hBD) ? 8'h08 : 8'h40, rdv);
      chk32(rdv, ev);
      rd(8'h04, rdv);
      chk32(rdv & 32'h00001F3F, {19'h0, ec[4:0], 2'b00, ec});
      chk1(er, 1'b0);
      rd(8'h10, rdv);
      chk32(rdv, pc_e);
      tn = tn + 1;
      $display("test %0d done", tn);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h04, rdv);
    chk32(rdv, 32'h00000000);
    rd(8'h30, rdv);
    chk1(er, 1'b1);
    run(32'h0,32'h0,32'h0,32'h11111111,16'hF0BD,32'h11111111,6'h00,1'b0,6'h01);
    run(32'h1,32'h3333,32'h0,32'h40000000,16'hF033,32'h3333,6'h00,1'b0,6'h01);
    run(32'h1,32'h3FF00000,32'h0,32'h0,16'hF0BD,32'h3F800000,6'h00,1'b0,6'h02);
    run(32'h1,32'h7FF00000,32'h0,32'h0,16'hF0BD,32'h7F800000,6'h00,1'b0,6'h02);
    run(32'h1,32'hFFF00000,32'h0,32'h0,16'hF0BD,32'hFF800000,6'h00,1'b0,6'h02);
    run(32'h1,32'h7FF00000,32'h1,32'h0,16'hF0BD,32'h7FBFFFFF,6'h00,1'b0,6'h02);
    run(32'h1,32'h7FF80000,32'h0,32'h0,16'hF0BD,32'h7FBFFFFF,6'h10,1'b0,6'h02);
    run(32'h1,32'h3FF00000,32'h18000000,32'h0,16'hF0BD,32'h3F800001,6'h01,1'b0,6'h02);
    run(32'h5,32'h3FF00000,32'h18000000,32'h0,16'hF0BD,32'h3F800000,6'h01,1'b0,6'h02);
    run(32'h1,32'h0,32'h20000000,32'h1234,16'hF0BD,32'h1234,6'h20,1'b1,6'h02);
    run(32'h3,32'h0,32'h20000000,32'h1234,16'hF0BD,32'h0,6'h00,1'b0,6'h02);
    run(32'h11,32'h3FF00000,32'h0,32'h1234,16'hF0BD,32'h1234,6'h00,1'b1,6'h02);
    run(32'h41,32'h47E00000,32'h0,32'h1234,16'hF0BD,32'h1234,6'h00,1'b1,6'h02);
    run(32'h41,32'h47D00000,32'h0,32'h1234,16'hF0BD,32'h7E800000,6'h00,1'b0,6'h02);
    run(32'h21,32'h38100000,32'h0,32'h1234,16'hF0BD,32'h00800000,6'h00,1'b0,6'h02);
    run(32'h1,32'h5555,32'h0,32'h3F800000,16'hF0AD,32'h3FF00000,6'h00,1'b0,6'h02);
    run(32'h1,32'h5555,32'h0,32'hFF800000,16'hF0AD,32'hFFF00000,6'h00,1'b0,6'h02);
    run(32'h1,32'h5555,32'h0,32'h1,16'hF0AD,32'h5555,6'h20,1'b1,6'h02);
    run(32'h3,32'h5555,32'h0,32'h1,16'hF0AD,32'h0,6'h00,1'b0,6'h02);
    run(32'h1,32'h5555,32'h0,32'h7F800001,16'hF0AD,32'h7FF7FFFF,6'h00,1'b0,6'h02);
    run(32'h1,32'h5555,32'h0,32'h7FC00000,16'hF0AD,32'h7FF7FFFF,6'h10,1'b0,6'h02);
    run(32'h0,32'h40C00000,32'h0,32'h40000000,16'hF023,32'h40400000,6'h00,1'b0,6'h0F);
    run(32'h0,32'h7F800000,32'h0,32'hC0000000,16'hF023,32'hFF800000,6'h00,1'b0,6'h0F);
    run(32'h100,32'h7FC00000,32'h0,32'h40000000,16'hF023,32'h7FC00000,6'h10,1'b1,6'h0F);
    run(32'h0,32'h7F800001,32'h0,32'h40000000,16'hF023,32'h7FBFFFFF,6'h00,1'b0,6'h0F);
    run(32'h0,32'h1,32'h0,32'h40000000,16'hF023,32'h1,6'h20,1'b1,6'h0F);
    run(32'h1,32'h40180000,32'h0,32'h40000000,16'hF023,32'h40080000,6'h00,1'b0,6'h1F);
    summarize;
  end
endmodule // tb
